/* sdac_write_ctrl.sv */
// Serial write front end and control registers of a 12-bit voltage output converter.
// Notes on behaviour
// [RL1] Frame starts on frame-sync falling edge.
// [RL2] Capture data on each clock falling edge.
// [RL3] Sixteenth edge executes frame, updates code/mode.
// [RL4] Host may hold or raise sync after.
// [RL5] Host keeps sync high 33 ns first.
// [RL6] Host may idle sync low between frames.
// [RL7] Host serial clock at most 30 MHz.
// [RL8] Two ignored bits, two mode, twelve code.
// [RL9] Early sync rise clears and discards frame.
// [RL10] Reset loads zero code, zero volts.
// [RL11] Mode 00 normal, others power-down kinds.
// [RL12] Power-down disables analog, selects termination.
// [RL13] Power-down keeps stored code unchanged.
// [RL14] Code is straight binary, zero to 4095.
// [RL15] Host data stable at falling clock edge.
// [RL16] Byte host keeps sync low two bytes.
// [RL17] Serial port host uses 16-bit words.
// [RL18] Host sends most significant bit first.
// [RL19] Extra edges ignored until new frame.
module sdac_write_ctrl
   import sdac_pkg::*;
#(
   parameter int FRAME_LEN = FRAME_BITS
) (
   // Core clock and reset.
   input wire logic core_clk_in,
   input wire logic rstn_in,
   // Serial pins from the host.
   input wire logic frame_sync_n_in,
   input wire logic shift_clock_in,
   input wire logic serial_data_in,
   // Converter code and mode.
   output logic [11:0] dac_code_out,
   output logic [1:0] mode_out,
   // Analog power and termination controls.
   output logic analog_enable_out,
   output logic term_1k_out,
   output logic term_100k_out,
   output logic term_open_out,
   // One-cycle pulse when a frame is executed.
   output logic update_out
);
   logic sync_level; // Synchronised frame sync.
   logic sync_fall; // Frame sync fell.
   logic sync_rise; // Frame sync rose.
   logic sclk_fall; // Shift clock fell.
   logic data_level; // Synchronised data bit.

   frame_state_e state_reg, state_next; // Receiver state.
   logic [15:0] shift_reg, shift_next; // Input shift register.
   logic [4:0] count_reg, count_next; // Edges taken this frame.
   logic [11:0] code_reg, code_next; // Converter code register.
   logic [1:0] mode_reg, mode_next; // Operating mode.
   logic update_reg; // Execute pulse.
   logic pwr_reg, t1k_reg, t100k_reg, topen_reg; // Registered controls.
   logic pwr_d, t1k_d, t100k_d, topen_d; // Decoded from the next mode.

   // Pin synchronisers; data is delayed as much as the clock so they align.
   // Frame sync idles high, so its stages reset high.
   sdac_sync #(
      .RESET_LEVEL(1'b1)
   ) u_sync_fs (
      .core_clk_in(core_clk_in),
      .rstn_in(rstn_in),
      .async_in(frame_sync_n_in),
      .level_out(sync_level),
      .fall_out(sync_fall),
      .rise_out(sync_rise)
   );
   // Shift clock idles low, so its stages reset low and no false fall follows reset.
   sdac_sync #(
      .RESET_LEVEL(1'b0)
   ) u_sync_sclk (
      .core_clk_in(core_clk_in),
      .rstn_in(rstn_in),
      .async_in(shift_clock_in),
      .level_out(),
      .fall_out(sclk_fall),
      .rise_out()
   );
   // Only the data level is used; its edges carry no meaning.
   sdac_sync #(
      .RESET_LEVEL(1'b0)
   ) u_sync_din (
      .core_clk_in(core_clk_in),
      .rstn_in(rstn_in),
      .async_in(serial_data_in),
      .level_out(data_level),
      .fall_out(),
      .rise_out()
   );

   // Edge is taken while sync is low and the frame is open.
   logic take_bit; // A falling shift clock edge inside an open frame.
   logic last_bit; // This edge is the sixteenth.
   logic [15:0] shifted; // Shift register with the new bit appended.
   assign take_bit = (state_reg == ST_SHIFT) && sclk_fall && !sync_level; // [RL2]
   assign last_bit = (count_reg == 5'(FRAME_LEN - 1));
   assign shifted = {shift_reg[FRAME_LEN-2:0], data_level}; // [RL2]

   // Field decoders; the receiver and its checks share them so both read a frame alike.
   // Mode field of a received frame, high bit first.
   function automatic logic [1:0] frame_mode(input logic [15:0] frame);
      frame_mode = {frame[MODE_HI_POS], frame[MODE_LO_POS]}; // [RL8]
   endfunction : frame_mode

   // Code field of a received frame, most significant bit first.
   function automatic logic [11:0] frame_code(input logic [15:0] frame);
      frame_code = frame[CODE_MSB_POS:0]; // [RL8]
   endfunction : frame_code

   // True in the cycle whose edge moves the receiver from shifting to done.
   function automatic logic frame_exec(input frame_state_e cur, input frame_state_e nxt);
      frame_exec = (cur == ST_SHIFT) && (nxt == ST_DONE);
   endfunction : frame_exec

   // Next-state logic for the frame receiver.
   // A frame opens on a synchronised sync fall, takes one bit per synchronised
   // shift clock fall and executes on the sixteenth. Synchronised sync high in
   // the shifting state aborts; the done state waits for sync to rise so that
   // edges past the sixteenth change nothing.
   always_comb begin
      state_next = state_reg;
      shift_next = shift_reg;
      count_next = count_reg;
      code_next = code_reg;
      mode_next = mode_reg;
      case (state_reg)
         ST_IDLE: begin
            // Only a fresh falling edge of sync opens a frame.
            if (sync_fall) begin
               state_next = ST_SHIFT; // [RL1]
               shift_next = SHIFT_RESET;
               count_next = COUNT_RESET;
            end
         end
         ST_SHIFT: begin
            if (sync_rise || sync_level) begin
               // Early rise aborts: clear and keep code and mode.
               state_next = ST_IDLE; // [RL9]
               shift_next = SHIFT_RESET; // [RL9]
               count_next = COUNT_RESET;
            end else if (take_bit) begin
               // Shift the bit in behind the earlier ones and count the edge.
               shift_next = shifted;
               count_next = count_reg + 5'h01;
               if (last_bit) begin
                  // Execute: mode from bits 13:12, code MSB first from 11:0.
                  state_next = ST_DONE; // [RL3]
                  mode_next = frame_mode(shifted); // [RL8] [RL11]
                  code_next = frame_code(shifted); // [RL8] [RL14]
               end
            end
         end
         ST_DONE: begin
            // Further edges are ignored until sync rises.
            if (sync_level) begin
               state_next = ST_IDLE; // [RL19]
            end
         end
         default: begin
            // A code outside the one-hot set goes back to idle.
            state_next = ST_IDLE;
         end
      endcase
   end

   // Mode decode of the next mode so controls register with it.
   sdac_mode_decode u_dec (
      .mode_in(mode_next), .powered_out(pwr_d), .term_1k_out(t1k_d),
      .term_100k_out(t100k_d), .term_open_out(topen_d)
   );

   // State and frame registers; reset gives zero code, normal mode.
   always_ff @(posedge core_clk_in) begin
      if (!rstn_in) begin
         // Power-up state: idle receiver, zero code, normal mode.
         state_reg <= ST_IDLE;
         shift_reg <= SHIFT_RESET;
         count_reg <= COUNT_RESET;
         code_reg <= CODE_RESET; // [RL10]
         mode_reg <= MODE_RESET; // [RL10]
      end else begin
         // Code and mode only move when the receiver executes a frame.
         state_reg <= state_next;
         shift_reg <= shift_next;
         count_reg <= count_next;
         code_reg <= code_next; // [RL13]
         mode_reg <= mode_next;
      end
   end

   // Registered analog controls and the execute pulse.
   always_ff @(posedge core_clk_in) begin
      if (!rstn_in) begin
         // Reset leaves the output stage powered with no termination.
         pwr_reg <= 1'b1;
         t1k_reg <= 1'b0;
         t100k_reg <= 1'b0;
         topen_reg <= 1'b0;
         update_reg <= 1'b0;
      end else begin
         // Controls register from the next mode so they change with mode_out.
         pwr_reg <= pwr_d; // [RL12]
         t1k_reg <= t1k_d; // [RL12]
         t100k_reg <= t100k_d;
         topen_reg <= topen_d;
         update_reg <= frame_exec(state_reg, state_next); // [RL3]
      end
   end

   // Outputs straight from flip-flops.
   // Nothing combinational reaches a top-level output.
   assign dac_code_out = code_reg;
   assign mode_out = mode_reg;
   assign analog_enable_out = pwr_reg;
   assign term_1k_out = t1k_reg;
   assign term_100k_out = t100k_reg;
   assign term_open_out = topen_reg;
   assign update_out = update_reg;

   // Checks on the frame receiver and the stored code and mode.
   // They watch registers and the logic decoded from them, so each holds on the core clock edge
   // without regard to where the host's pin edges fall.
   // Code changes only on an execute.
   code_hold_a: assert property (@(posedge core_clk_in) disable iff (!rstn_in) // [RL9]
      !update_reg |-> $stable(code_reg) || $past(state_next == ST_DONE && state_reg == ST_SHIFT))
      else $error("code changed without frame execute");
   // Execute happens only after sixteen edges.
   exec_count_a: assert property (@(posedge core_clk_in) disable iff (!rstn_in) // [RL3]
      update_reg |-> count_reg == 5'(FRAME_LEN))
      else $error("execute without sixteen edges");
   // Abort clears the shift register.
   abort_clear_a: assert property (@(posedge core_clk_in) disable iff (!rstn_in) // [RL9]
      (state_reg == ST_SHIFT && sync_level) |=> shift_reg == SHIFT_RESET && state_reg == ST_IDLE)
      else $error("abort did not clear shift register");
   // Mode matches the received bits after execute.
   mode_load_a: assert property (@(posedge core_clk_in) disable iff (!rstn_in) // [RL11]
      update_reg |-> mode_reg == frame_mode(shift_reg))
      else $error("mode not taken from frame");
   // Code matches the low twelve bits.
   code_load_a: assert property (@(posedge core_clk_in) disable iff (!rstn_in) // [RL8]
      update_reg |-> code_reg == frame_code(shift_reg))
      else $error("code not taken from frame");
   // Power follows mode in the same cycle.
   power_follow_a: assert property (@(posedge core_clk_in) disable iff (!rstn_in) // [RL12]
      analog_enable_out == (mode_reg == MODE_NORMAL))
      else $error("analog enable disagrees with mode");
   // Done state ignores edges.
   done_ignore_a: assert property (@(posedge core_clk_in) disable iff (!rstn_in) // [RL19]
      (state_reg == ST_DONE && !sync_level) |=> $stable(shift_reg) && $stable(code_reg))
      else $error("edge after sixteenth was taken");
   // Frame opens only from a sync fall.
   frame_open_a: assert property (@(posedge core_clk_in) disable iff (!rstn_in) // [RL1]
      (state_reg == ST_IDLE && !sync_fall) |=> state_reg == ST_IDLE)
      else $error("frame opened without sync fall");
   // A sync fall in idle opens a frame with a fresh count.
   frame_start_a: assert property (@(posedge core_clk_in) disable iff (!rstn_in) // [RL1]
      (state_reg == ST_IDLE && sync_fall) |=> state_reg == ST_SHIFT && count_reg == COUNT_RESET)
      else $error("sync fall did not open a frame");
   // Each taken edge before the sixteenth adds one to the count.
   count_step_a: assert property (@(posedge core_clk_in) disable iff (!rstn_in) // [RL2]
      (take_bit && !last_bit) |=> count_reg == $past(count_reg) + 5'h01)
      else $error("taken edge not counted");
   // Each taken edge shifts the sampled data bit in.
   shift_take_a: assert property (@(posedge core_clk_in) disable iff (!rstn_in) // [RL2]
      take_bit |=> shift_reg == $past(shifted))
      else $error("data bit not shifted in");
   // The count never runs past one frame.
   count_bound_a: assert property (@(posedge core_clk_in) disable iff (!rstn_in) // [RL19]
      count_reg <= 5'(FRAME_LEN))
      else $error("edge count ran past the frame");
   // An abort keeps the stored code and mode.
   abort_keep_a: assert property (@(posedge core_clk_in) disable iff (!rstn_in) // [RL9]
      (state_reg == ST_SHIFT && sync_level) |=> $stable(code_reg) && $stable(mode_reg))
      else $error("abort changed code or mode");
   // Mode changes only on an execute.
   mode_hold_a: assert property (@(posedge core_clk_in) disable iff (!rstn_in) // [RL9]
      !update_reg |-> $stable(mode_reg))
      else $error("mode changed without frame execute");
   // The execute pulse lasts one cycle and comes with the done state.
   update_pulse_a: assert property (@(posedge core_clk_in) disable iff (!rstn_in) // [RL3]
      update_reg |-> state_reg == ST_DONE ##1 !update_reg)
      else $error("execute pulse out of place");
   // Exactly one of power and the three terminations is selected.
   term_onehot_a: assert property (@(posedge core_clk_in) disable iff (!rstn_in) // [RL12]
      $onehot({analog_enable_out, term_1k_out, term_100k_out, term_open_out}))
      else $error("output stage selection not one-hot");
   // Each termination matches its mode code.
   term_select_a: assert property (@(posedge core_clk_in) disable iff (!rstn_in) // [RL11]
      {term_1k_out, term_100k_out, term_open_out} ==
      {mode_reg == MODE_PD_1K, mode_reg == MODE_PD_100K, mode_reg == MODE_PD_OPEN})
      else $error("termination select disagrees with mode");

   // Main scenarios that the bench should reach.
   full_frame_c: cover property (@(posedge core_clk_in) disable iff (!rstn_in) update_reg);
   abort_c: cover property (@(posedge core_clk_in) disable iff (!rstn_in)
      state_reg == ST_SHIFT && sync_rise && count_reg != COUNT_RESET);
   powerdown_c: cover property (@(posedge core_clk_in) disable iff (!rstn_in) update_reg && !pwr_d);
   open_mode_c: cover property (@(posedge core_clk_in) disable iff (!rstn_in) update_reg && term_open_out);
   extra_edge_c: cover property (@(posedge core_clk_in) disable iff (!rstn_in) state_reg == ST_DONE && sclk_fall);
endmodule : sdac_write_ctrl

/* sdac_pkg.sv */
// Shared constants for the serial converter write front end.
package sdac_pkg;
   // Frame layout.
   localparam int FRAME_BITS = 16;
   localparam int CODE_BITS = 12;
   localparam int MODE_HI_POS = 13;
   localparam int MODE_LO_POS = 12;
   localparam int CODE_MSB_POS = 11;
   // Reset values.
   localparam logic [11:0] CODE_RESET = 12'h000;
   localparam logic [1:0] MODE_RESET = 2'h0;
   localparam logic [15:0] SHIFT_RESET = 16'h0000;
   localparam logic [4:0] COUNT_RESET = 5'h00;
   // Frame-sync high-time figures, kept for reference.
   localparam int CLK_PERIOD_PS = 4000;
   localparam int SYNC_HIGH_MIN_PS = 33000;
   localparam int SYNC_HIGH_CYC = (SYNC_HIGH_MIN_PS + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
   // Mode encodings.
   localparam logic [1:0] MODE_NORMAL = 2'h0;
   localparam logic [1:0] MODE_PD_1K = 2'h1;
   localparam logic [1:0] MODE_PD_100K = 2'h2;
   localparam logic [1:0] MODE_PD_OPEN = 2'h3;
   // Frame receiver states, one-hot.
   typedef enum logic [2:0] {
      ST_IDLE = 3'b001,
      ST_SHIFT = 3'b010,
      ST_DONE = 3'b100
   } frame_state_e;
endpackage : sdac_pkg

/* sdac_sync.sv */
// Two-stage synchroniser with falling and rising edge detection.
module sdac_sync #(
   // Level the stages take in reset; it matches the pin's idle level so no false edge follows reset.
   parameter logic RESET_LEVEL = 1'b1
) (
   // Clock and reset.
   input wire logic core_clk_in,
   input wire logic rstn_in,
   // Asynchronous input.
   input wire logic async_in,
   // Synchronised level and edges.
   output logic level_out,
   output logic fall_out,
   output logic rise_out
);
   logic meta_reg; // First stage, read only by the second.
   logic sync_reg; // Second stage.
   logic prev_reg; // Delayed copy for edge detection.

   // Shift the input through the stages; all reset to the pin's idle level.
   always_ff @(posedge core_clk_in) begin
      if (!rstn_in) begin
         meta_reg <= RESET_LEVEL;
         sync_reg <= RESET_LEVEL;
         prev_reg <= RESET_LEVEL;
      end else begin
         meta_reg <= async_in;
         sync_reg <= meta_reg;
         prev_reg <= sync_reg;
      end
   end

   // Edges come from the second and third stages only.
   assign level_out = sync_reg;
   assign fall_out = prev_reg & ~sync_reg;
   assign rise_out = ~prev_reg & sync_reg;
endmodule : sdac_sync

/* sdac_mode_decode.sv */
// Decodes the stored mode into power and output termination controls.
module sdac_mode_decode
   import sdac_pkg::*;
(
   // Stored mode.
   input wire logic [1:0] mode_in,
   // Power and termination controls.
   output logic powered_out,
   output logic term_1k_out,
   output logic term_100k_out,
   output logic term_open_out
);
   // Any nonzero mode shuts down bias, amplifier and string.
   assign powered_out = (mode_in == MODE_NORMAL);
   assign term_1k_out = (mode_in == MODE_PD_1K);
   assign term_100k_out = (mode_in == MODE_PD_100K);
   assign term_open_out = (mode_in == MODE_PD_OPEN);
endmodule : sdac_mode_decode

/* sdac_host_model.sv */
// Behavioural host that drives write frames onto the serial pins.
module sdac_host_model (
   // Serial pins towards the converter.
   output logic frame_sync_n_out,
   output logic shift_clock_out,
   output logic serial_data_out
);
   timeunit 1ns;
   timeprecision 100ps;

   // The pins idle with sync high and the clock still and low.
   initial begin
      frame_sync_n_out = 1'b1;
      shift_clock_out = 1'b0;
      serial_data_out = 1'b0;
   end

   // Sends nbits of word, most significant bit first, with an optional frame start and end.
   task automatic xfer(input logic [15:0] word, input int nbits, input bit start, input bit stop);
      int i;
      if (start) begin
         // A sync left low is raised briefly so that a fresh falling edge exists.
         if (frame_sync_n_out === 1'b0) begin
            frame_sync_n_out = 1'b1;
            #40;
         end
         frame_sync_n_out = 1'b0;
         #62.5;
      end
      // Data changes on the rising edge and so is stable at each falling edge.
      for (i = 0; i < nbits; i++) begin
         shift_clock_out = 1'b1;
         serial_data_out = word[15 - (i % 16)];
         #62.5;
         shift_clock_out = 1'b0;
         #62.5;
      end
      // A released data line shows the inverse of its last value, never a held copy.
      if (stop) begin
         frame_sync_n_out = 1'b1;
         serial_data_out = ~serial_data_out;
         #40;
      end
   endtask : xfer
endmodule : sdac_host_model

/* tb_serial_dac_write_control.sv */
// Self-checking bench for the serial converter write front end.
module tb_serial_dac_write_control
   import sdac_pkg::*;
;
   timeunit 1ns;
   timeprecision 100ps;

   logic core_clk_in; // Core clock.
   logic rstn_in; // Synchronous reset, active low.
   logic frame_sync_n, shift_clock, serial_data; // Host pins.
   logic [11:0] dac_code_out; // Stored code.
   logic [1:0] mode_out; // Stored mode.
   logic analog_enable_out, term_1k_out, term_100k_out, term_open_out; // Power controls.
   logic update_out; // Execute pulse.
   int mismatches = 0; // Failed comparisons.
   int checked = 0; // All comparisons.
   int updates = 0; // Execute pulses seen.

   // The clock toggles every 2 ns, half of its 4 ns period.
   initial begin
      core_clk_in = 1'b0;
      forever #2 core_clk_in = ~core_clk_in;
   end

   // Execute pulses are counted mid-cycle, where the registered pulse is settled.
   always @(negedge core_clk_in) begin
      if (update_out === 1'b1) updates++;
   end

   sdac_host_model u_host (
      .frame_sync_n_out(frame_sync_n),
      .shift_clock_out(shift_clock),
      .serial_data_out(serial_data)
   );

   sdac_write_ctrl u_dut (
      .core_clk_in(core_clk_in),
      .rstn_in(rstn_in),
      .frame_sync_n_in(frame_sync_n),
      .shift_clock_in(shift_clock),
      .serial_data_in(serial_data),
      .dac_code_out(dac_code_out),
      .mode_out(mode_out),
      .analog_enable_out(analog_enable_out),
      .term_1k_out(term_1k_out),
      .term_100k_out(term_100k_out),
      .term_open_out(term_open_out),
      .update_out(update_out)
   );

   // Compares one value and reports a mismatch at once.
   task automatic check(input logic [15:0] got, input logic [15:0] exp);
      checked++;
      if (got !== exp) begin
         mismatches++;
         $display("wrong value at %0t: got %h expected %h", $time, got, exp);
      end
   endtask : check

   // Lets the outputs settle, then judges code, mode, controls and pulse count.
   task automatic judge(input logic [11:0] c, input logic [1:0] m, input int u);
      logic [3:0] ctl;
      ctl = 4'h8 >> m;
      repeat (8) @(negedge core_clk_in);
      check({4'h0, dac_code_out}, {4'h0, c});
      check({14'h0000, mode_out}, {14'h0000, m});
      check({12'h000, analog_enable_out, term_1k_out, term_100k_out, term_open_out}, {12'h000, ctl});
      check(16'(updates), 16'(u));
   endtask : judge

   // Reset clears code and mode and leaves the output stage powered.
   task automatic t_reset(input int u);
      rstn_in = 1'b0;
      repeat (3) @(negedge core_clk_in);
      rstn_in = 1'b1;
      judge(12'h000, 2'h0, u);
      $display("test reset done");
   endtask : t_reset

   // Two leading ones are ignored and the code is taken most significant bit first.
   task automatic t_normal();
      u_host.xfer(16'hCABC, 16, 1'b1, 1'b1);
      judge(12'hABC, 2'h0, 1);
      $display("test normal done");
   endtask : t_normal

   // Every power-down mode keeps the code; normal mode then loads full scale.
   task automatic t_modes();
      int m;
      for (m = 1; m < 4; m++) begin
         u_host.xfer({2'h0, 2'(m), 12'hABC}, 16, 1'b1, 1'b1);
         judge(12'hABC, 2'(m), 1 + m);
      end
      u_host.xfer(16'h0FFF, 16, 1'b1, 1'b1);
      judge(12'hFFF, 2'h0, 5);
      $display("test modes done");
   endtask : t_modes

   // An early sync rise discards the frame; the next frame starts clean.
   task automatic t_abort();
      u_host.xfer(16'h2123, 10, 1'b1, 1'b1);
      judge(12'hFFF, 2'h0, 5);
      u_host.xfer(16'h0456, 16, 1'b1, 1'b1);
      judge(12'h456, 2'h0, 6);
      $display("test abort done");
   endtask : t_abort

   // Edges beyond the sixteenth are ignored; sync idles low before the next frame.
   task automatic t_extra();
      u_host.xfer(16'h0789, 20, 1'b1, 1'b0);
      judge(12'h789, 2'h0, 7);
      u_host.xfer(16'h3000, 16, 1'b1, 1'b1);
      judge(12'h000, 2'h3, 8);
      $display("test extra done");
   endtask : t_extra

   // Two bytes under one low sync form one frame; one byte alone does nothing.
   task automatic t_bytes();
      u_host.xfer(16'h0A00, 8, 1'b1, 1'b0);
      judge(12'h000, 2'h3, 8);
      u_host.xfer(16'h5A00, 8, 1'b0, 1'b1);
      judge(12'hA5A, 2'h0, 9);
      $display("test bytes done");
   endtask : t_bytes

   // Prints the counts and the verdict, then ends the run.
   task automatic print_verdict();
      $display("checked %0d mismatches %0d", checked, mismatches);
      if (mismatches == 0 && checked > 0) begin
         $display("ALL CHECKS OK");
      end else begin
         $display("CHECKS NOT OK");
      end
      $finish;
   endtask : print_verdict

   // Main sequence: reset for 3 cycles, each scenario in turn, then a second reset just before the verdict.
   initial begin
      t_reset(0);
      t_normal();
      t_modes();
      t_abort();
      t_extra();
      t_bytes();
      t_reset(9);
      print_verdict();
   end

   // The run takes some 21 us; a hang is cut off well after that.
   initial begin
      #200000;
      mismatches++;
      print_verdict();
   end
endmodule : tb_serial_dac_write_control
